// ==== pkg/nvc_map.svh ====
// Register offsets, field positions, reset values and timing counts of the nv control block.
`ifndef NVC_MAP_SVH
`define NVC_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define NVC_OFF_CONTROL   8'h00
`define NVC_OFF_KEY       8'h04
`define NVC_OFF_ADDR_LOW  8'h08
`define NVC_OFF_ADDR_HIGH 8'h0C
`define NVC_OFF_DATA_LOW  8'h10
`define NVC_OFF_DATA_HIGH 8'h14

// ****************************************
// Control register fields and reset value
// ****************************************
`define NVC_BIT_READ_START    0
`define NVC_BIT_WRITE_START   1
`define NVC_BIT_WRITE_ENABLE  2
`define NVC_BIT_WRITE_ERROR   3
`define NVC_BIT_ERASE_SELECT  4
`define NVC_BIT_LATCH_ONLY    5
`define NVC_BIT_CONFIG_SPACE  6
`define NVC_BIT_PROGRAM_SPACE 7
`define NVC_CONTROL_RESET     8'h00

// ****************************************
// Unlock pattern and bus answers
// ****************************************
`define NVC_KEY_FIRST  8'h55
`define NVC_KEY_SECOND 8'hAA
`define NVC_RESP_OKAY   2'b00
`define NVC_RESP_SLVERR 2'b10

// ****************************************
// Self-timed program and erase duration
// ****************************************
`define NVC_CLK_PERIOD_NS 40
`define NVC_PROG_TIME_NS  2000
`define NVC_PROG_CYC ((`NVC_PROG_TIME_NS + `NVC_CLK_PERIOD_NS - 1) / `NVC_CLK_PERIOD_NS)

`endif

// ==== pkg/nvc_pkg.sv ====
// Types shared by the nv control block modules.
`default_nettype none
`include "nvc_map.svh"
package nvc_pkg;
	typedef enum logic [1:0] {NVC_OP_LATCH, NVC_OP_WRITE, NVC_OP_ERASE, NVC_OP_ERASE_WRITE} nvc_op_e;
	typedef enum logic [1:0] {NVC_ENG_IDLE, NVC_ENG_ERASE, NVC_ENG_WRITE} nvc_eng_e;
	typedef enum logic [1:0] {NVC_UL_IDLE, NVC_UL_HALF, NVC_UL_OPEN} nvc_ul_e;
	typedef logic [7:0] nvc_byte_t;
endpackage : nvc_pkg
`default_nettype wire

// ==== pkg/nvc_link_if.sv ====
// Internal links between the control block, the unlock checker and the timing engine.
`timescale 1ns/1ps
`default_nettype none
interface nvc_link_if
	import nvc_pkg::*;
	();
	logic      keyWrite;
	nvc_byte_t keyData;
	logic      otherWrite;
	logic      unlocked;
	logic      start;
	nvc_op_e   op;
	logic      abort;
	logic      erasing;
	logic      writing;
	logic      latchStb;
	logic      doneOk;
	logic      doneFault;
	logic      eraseDone;

	modport unl (input keyWrite, keyData, otherWrite, output unlocked);
	modport eng (input start, op, abort,
		output erasing, writing, latchStb, doneOk, doneFault, eraseDone);
endinterface : nvc_link_if
`default_nettype wire

// ==== design/nvc_unlock.sv ====
// Unlock key checker: tracks the two-byte pattern written to the key port.
`timescale 1ns/1ps
`default_nettype none
`include "nvc_map.svh"
module nvc_unlock
	import nvc_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic reset,
	// Link to the control block
	nvc_link_if.unl   link
);
	typedef struct packed {
		nvc_ul_e state;
	} nvc_ul_s;

	nvc_ul_s r;
	nvc_ul_s next_r;

	always_comb begin
		next_r = r;
		if (link.keyWrite) begin
			if (link.keyData == `NVC_KEY_FIRST) begin
				next_r.state = NVC_UL_HALF;
			end else if (link.keyData == `NVC_KEY_SECOND && r.state == NVC_UL_HALF) begin
				next_r.state = NVC_UL_OPEN;
			end else begin
				next_r.state = NVC_UL_IDLE;
			end
		end else if (link.otherWrite) begin
			next_r.state = NVC_UL_IDLE;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign link.unlocked = (r.state == NVC_UL_OPEN);

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_pair_opens: assert property (link.keyWrite && link.keyData == `NVC_KEY_SECOND &&
		r.state == NVC_UL_HALF |=> link.unlocked)
		else $error("Key pattern did not unlock.");
	a_other_locks: assert property (link.otherWrite && !link.keyWrite |=> !link.unlocked)
		else $error("Gate stayed open after another write.");
endmodule : nvc_unlock
`default_nettype wire

// ==== design/nvc_engine.sv ====
// Self-timed engine for latch loads, erases and writes of the memory arrays.
`timescale 1ns/1ps
`default_nettype none
`include "nvc_map.svh"
module nvc_engine
	import nvc_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic reset,
	// Link to the control block
	nvc_link_if.eng   link
);
	localparam logic [7:0] ProgLast = 8'(`NVC_PROG_CYC - 1);
	localparam int MaxOpCyc = 2 * `NVC_PROG_CYC + 2;

	typedef struct packed {
		nvc_eng_e   state;
		logic [7:0] count;
		nvc_op_e    op;
		logic       latchStb;
		logic       doneOk;
		logic       doneFault;
		logic       eraseDone;
	} nvc_eng_s;

	nvc_eng_s r;
	nvc_eng_s next_r;

	always_comb begin
		next_r = r;
		next_r.latchStb = 1'b0;
		next_r.doneOk = 1'b0;
		next_r.doneFault = 1'b0;
		next_r.eraseDone = 1'b0;
		case (r.state)
			NVC_ENG_IDLE: begin
				if (link.start) begin
					next_r.op = link.op;
					next_r.count = ProgLast;
					case (link.op)
						NVC_OP_LATCH: begin
							next_r.latchStb = 1'b1;
							next_r.doneOk = 1'b1;
						end
						NVC_OP_WRITE: next_r.state = NVC_ENG_WRITE;
						default: next_r.state = NVC_ENG_ERASE;
					endcase
				end
			end
			NVC_ENG_ERASE: begin
				if (link.abort) begin
					next_r.state = NVC_ENG_IDLE;
					next_r.doneFault = 1'b1;
				end else if (r.count == '0) begin
					next_r.eraseDone = 1'b1;
					next_r.count = ProgLast;
					if (r.op == NVC_OP_ERASE) begin
						next_r.state = NVC_ENG_IDLE;
						next_r.doneOk = 1'b1;
					end else begin
						next_r.state = NVC_ENG_WRITE;
					end
				end else begin
					next_r.count = r.count - 8'h01;
				end
			end
			NVC_ENG_WRITE: begin
				if (link.abort) begin
					next_r.state = NVC_ENG_IDLE;
					next_r.doneFault = 1'b1;
				end else if (r.count == '0) begin
					next_r.state = NVC_ENG_IDLE;
					next_r.doneOk = 1'b1;
				end else begin
					next_r.count = r.count - 8'h01;
				end
			end
			default: next_r.state = NVC_ENG_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign link.erasing = (r.state == NVC_ENG_ERASE);
	assign link.writing = (r.state == NVC_ENG_WRITE);
	assign link.latchStb = r.latchStb;
	assign link.doneOk = r.doneOk;
	assign link.doneFault = r.doneFault;
	assign link.eraseDone = r.eraseDone;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_op_finishes: assert property (link.start |-> ##[1:MaxOpCyc] (link.doneOk || link.doneFault))
		else $error("Operation did not finish in time.");
	a_abort_fault: assert property ((link.erasing || link.writing) && link.abort |=> link.doneFault)
		else $error("Abort did not report a fault.");
endmodule : nvc_engine
`default_nettype wire

// ==== design/nvc_top.sv ====
// Nonvolatile memory self-write control with an AXI4-Lite register slave.
//
// Functional notes
// - Improper or aborted sequence sets error flag.
// - Any write-one to write start sets error.
// - Clean completion clears error flag, except under a same-cycle write-one to write start.
// - Key port is write-only, never stored.
// - Key value only decides the unlock.
// - High address 7 bits, high data 6.
// - Erase select makes flash starts erase.
`timescale 1ns/1ps
`default_nettype none
`include "nvc_map.svh"
module nvc_top
	import nvc_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// AXI4-Lite write channels
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read channels
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Memory array port
	output logic [14:0]      memAddr,
	output logic [13:0]      memWrData,
	input  wire logic [13:0] memRdData,
	output logic             memReadStb,
	output logic             memLatchStb,
	output logic             memEraseActive,
	output logic             memWriteActive,
	// Supply monitor and completion event
	input  wire logic        abortPin,
	output logic             completionIrqSet
);
	typedef struct packed {
		logic       awHeld;
		nvc_byte_t  awAddr;
		logic       wHeld;
		nvc_byte_t  wData;
		logic       wLane;
		logic       bValid;
		logic [1:0] bResp;
		logic       rValid;
		nvc_byte_t  rData;
		logic [1:0] rResp;
		logic       programSpaceSelect;
		logic       configSpaceSelect;
		logic       latchOnlySelect;
		logic       eraseSelect;
		logic       writeErrorFlag;
		logic       writeEnableGate;
		logic       writeStart;
		logic       readStart;
		nvc_byte_t  addrLow;
		logic [6:0] addrHigh;
		nvc_byte_t  dataLow;
		logic [5:0] dataHigh;
		logic       abortMeta;
		logic       abortSync;
		logic       irqSet;
	} nvc_top_s;

	nvc_top_s r;
	nvc_top_s next_r;

	logic    awTake;
	logic    wTake;
	logic    arTake;
	logic    wrDo;
	logic    wrMapped;
	logic    ctrlWr;
	logic    keyWr;
	logic    wrSetTry;
	logic    startNow;
	nvc_op_e opSel;

	nvc_link_if link ();

	// ****************************************
	// Unlock checker and timing engine
	// ****************************************
	nvc_unlock u_unlock (
		.clock (clock),
		.reset (reset),
		.link  (link.unl)
	);

	nvc_engine u_engine (
		.clock (clock),
		.reset (reset),
		.link  (link.eng)
	);

	// ****************************************
	// Register read and decode helpers
	// ****************************************
	function automatic logic isMapped(input nvc_byte_t a);
		isMapped = (a == `NVC_OFF_CONTROL) || (a == `NVC_OFF_KEY) ||
			(a == `NVC_OFF_ADDR_LOW) || (a == `NVC_OFF_ADDR_HIGH) ||
			(a == `NVC_OFF_DATA_LOW) || (a == `NVC_OFF_DATA_HIGH);
	endfunction : isMapped

	function automatic nvc_byte_t readReg(input nvc_byte_t a, input nvc_top_s s);
		readReg = 8'h00;
		case (a)
			`NVC_OFF_CONTROL: begin
				readReg[`NVC_BIT_PROGRAM_SPACE] = s.programSpaceSelect;
				readReg[`NVC_BIT_CONFIG_SPACE] = s.configSpaceSelect;
				readReg[`NVC_BIT_LATCH_ONLY] = s.latchOnlySelect;
				readReg[`NVC_BIT_ERASE_SELECT] = s.eraseSelect;
				readReg[`NVC_BIT_WRITE_ERROR] = s.writeErrorFlag;
				readReg[`NVC_BIT_WRITE_ENABLE] = s.writeEnableGate;
				readReg[`NVC_BIT_WRITE_START] = s.writeStart;
				readReg[`NVC_BIT_READ_START] = s.readStart;
			end
			`NVC_OFF_ADDR_LOW: readReg = s.addrLow;
			`NVC_OFF_ADDR_HIGH: readReg = {1'b0, s.addrHigh};
			`NVC_OFF_DATA_LOW: readReg = s.dataLow;
			`NVC_OFF_DATA_HIGH: readReg = {2'b00, s.dataHigh};
			default: readReg = 8'h00;
		endcase
	endfunction : readReg

	// ****************************************
	// Bus handshakes and write decode
	// ****************************************
	assign s_axi_awready = !r.awHeld && !r.bValid;
	assign s_axi_wready = !r.wHeld && !r.bValid;
	assign s_axi_arready = !r.rValid;
	assign awTake = s_axi_awvalid && s_axi_awready;
	assign wTake = s_axi_wvalid && s_axi_wready;
	assign arTake = s_axi_arvalid && s_axi_arready;
	assign wrDo = r.awHeld && r.wHeld;
	assign wrMapped = isMapped(r.awAddr);
	assign ctrlWr = wrDo && r.wLane && (r.awAddr == `NVC_OFF_CONTROL);
	assign keyWr = wrDo && r.wLane && (r.awAddr == `NVC_OFF_KEY);
	assign wrSetTry = ctrlWr && r.wData[`NVC_BIT_WRITE_START];

	always_comb begin
		if (r.configSpaceSelect || r.programSpaceSelect) begin
			if (r.eraseSelect) begin
				opSel = NVC_OP_ERASE;
			end else if (r.latchOnlySelect) begin
				opSel = NVC_OP_LATCH;
			end else begin
				opSel = NVC_OP_WRITE;
			end
		end else begin
			opSel = NVC_OP_ERASE_WRITE;
		end
	end

	assign startNow = wrSetTry && r.writeEnableGate && link.unlocked &&
		!r.writeStart && !r.readStart;

	assign link.keyWrite = keyWr;
	assign link.keyData = r.wData;
	assign link.otherWrite = wrDo && !keyWr;
	assign link.start = startNow;
	assign link.op = opSel;
	assign link.abort = r.abortSync;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_r = r;
		next_r.abortMeta = abortPin;
		next_r.abortSync = r.abortMeta;
		next_r.irqSet = link.doneOk;
		if (awTake) begin
			next_r.awHeld = 1'b1;
			next_r.awAddr = s_axi_awaddr;
		end
		if (wTake) begin
			next_r.wHeld = 1'b1;
			next_r.wData = s_axi_wdata[7:0];
			next_r.wLane = s_axi_wstrb[0];
		end
		if (r.bValid && s_axi_bready) begin
			next_r.bValid = 1'b0;
		end
		if (wrDo) begin
			next_r.awHeld = 1'b0;
			next_r.wHeld = 1'b0;
			next_r.bValid = 1'b1;
			next_r.bResp = wrMapped ? `NVC_RESP_OKAY : `NVC_RESP_SLVERR;
		end
		if (r.rValid && s_axi_rready) begin
			next_r.rValid = 1'b0;
		end
		if (arTake) begin
			next_r.rValid = 1'b1;
			next_r.rData = readReg(s_axi_araddr, r);
			next_r.rResp = isMapped(s_axi_araddr) ? `NVC_RESP_OKAY : `NVC_RESP_SLVERR;
		end
		if (wrDo && r.wLane && !r.writeStart) begin
			case (r.awAddr)
				`NVC_OFF_ADDR_LOW: next_r.addrLow = r.wData;
				`NVC_OFF_ADDR_HIGH: next_r.addrHigh = r.wData[6:0];
				`NVC_OFF_DATA_LOW: next_r.dataLow = r.wData;
				`NVC_OFF_DATA_HIGH: next_r.dataHigh = r.wData[5:0];
				default: next_r.addrLow = r.addrLow;
			endcase
		end
		if (r.readStart) begin
			next_r.readStart = 1'b0;
			next_r.dataLow = memRdData[7:0];
			next_r.dataHigh = memRdData[13:8];
		end
		if (ctrlWr) begin
			next_r.programSpaceSelect = r.wData[`NVC_BIT_PROGRAM_SPACE];
			next_r.configSpaceSelect = r.wData[`NVC_BIT_CONFIG_SPACE];
			next_r.latchOnlySelect = r.wData[`NVC_BIT_LATCH_ONLY];
			next_r.eraseSelect = r.wData[`NVC_BIT_ERASE_SELECT];
			next_r.writeEnableGate = r.wData[`NVC_BIT_WRITE_ENABLE];
			if (!r.wData[`NVC_BIT_WRITE_ERROR]) begin
				next_r.writeErrorFlag = 1'b0;
			end
			if (r.wData[`NVC_BIT_READ_START] && !r.writeStart) begin
				next_r.readStart = 1'b1;
			end
		end
		if (link.eraseDone) begin
			next_r.eraseSelect = 1'b0;
		end
		if (link.doneOk) begin
			next_r.writeErrorFlag = 1'b0;
			next_r.writeStart = 1'b0;
		end
		if (link.doneFault) begin
			next_r.writeStart = 1'b0;
		end
		if (startNow) begin
			next_r.writeStart = 1'b1;
		end
		if (wrSetTry || link.doneFault) begin
			next_r.writeErrorFlag = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign s_axi_bvalid = r.bValid;
	assign s_axi_bresp = r.bResp;
	assign s_axi_rvalid = r.rValid;
	assign s_axi_rdata = {24'h0000_00, r.rData};
	assign s_axi_rresp = r.rResp;
	assign memAddr = {r.addrHigh, r.addrLow};
	assign memWrData = {r.dataHigh, r.dataLow};
	assign memReadStb = r.readStart;
	assign memLatchStb = link.latchStb;
	assign memEraseActive = link.erasing;
	assign memWriteActive = link.writing;
	assign completionIrqSet = r.irqSet;

	// ****************************************
	// Assertions and covers
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_write_error_flag_on_set: assert property (wrSetTry |=> r.writeErrorFlag)
		else $error("Write start attempt left the error flag clear.");
	a_fault_sets_err: assert property (link.doneFault |=> r.writeErrorFlag && !r.writeStart)
		else $error("Fault did not set the error flag.");
	a_clean_clears: assert property (link.doneOk && !wrSetTry |=> !r.writeErrorFlag ##0
		completionIrqSet)
		else $error("Clean completion left the error flag set.");
	a_start_unlocked: assert property ((link.erasing || link.writing || link.latchStb) &&
		!$past(link.erasing || link.writing) |-> $past(r.writeEnableGate && link.unlocked))
		else $error("Operation started without gate or unlock.");
	a_read_one_cycle: assert property ($rose(r.readStart) |=> !r.readStart)
		else $error("Read start held for more than one cycle.");
	a_addrh_zero: assert property (arTake && s_axi_araddr == `NVC_OFF_ADDR_HIGH
		|=> s_axi_rdata[31:7] == '0)
		else $error("Unimplemented high address bits read as one.");
	a_key_not_stored: assert property (arTake && s_axi_araddr == `NVC_OFF_KEY
		|=> s_axi_rdata == '0)
		else $error("Key port returned stored data.");
	a_erase_select: assert property (link.start && r.eraseSelect &&
		(r.configSpaceSelect || r.programSpaceSelect) |=> link.erasing && !link.writing)
		else $error("Erase select did not choose an erase.");

	c_write_done: cover property (link.start ##[1:120] link.doneOk);
	c_write_fault: cover property (link.writing ##1 link.doneFault);
	c_locked_try: cover property (wrSetTry && !link.unlocked);
	c_read: cover property (r.readStart);
endmodule : nvc_top
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking testbench of the nv control block.
`timescale 1ns/1ps
`default_nettype none
`include "nvc_map.svh"
module tb
	import nvc_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	localparam nvc_byte_t CTRL = `NVC_OFF_CONTROL;
	localparam nvc_byte_t KEY  = `NVC_OFF_KEY;
	logic        clock, reset, abortPin, completionIrqSet;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdData;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, lastResp;
	logic [14:0] memAddr;
	logic [13:0] memWrData, memRdData;
	logic        memReadStb, memLatchStb, memEraseActive, memWriteActive;
	int          n_mismatch = 0, n_checks = 0, cycles = 0;
	int          eraseCyc = 0, writeCyc = 0, latchCnt = 0, readCnt = 0, irqCnt = 0;

	// ****************************************
	// Design under test
	// ****************************************
	nvc_top dut (.clock(clock), .reset(reset),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData),
		.memReadStb(memReadStb), .memLatchStb(memLatchStb),
		.memEraseActive(memEraseActive), .memWriteActive(memWriteActive),
		.abortPin(abortPin), .completionIrqSet(completionIrqSet));

	// ****************************************
	// Clock, activity counters and timeout
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		eraseCyc <= eraseCyc + int'(memEraseActive === 1'b1);
		writeCyc <= writeCyc + int'(memWriteActive === 1'b1);
		latchCnt <= latchCnt + int'(memLatchStb === 1'b1);
		readCnt <= readCnt + int'(memReadStb === 1'b1);
		irqCnt <= irqCnt + int'(completionIrqSet === 1'b1);
		if (cycles == 30000) begin
			n_mismatch = n_mismatch + 1;
			final_report();
		end
	end

	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
		logic awDone, wDone, awTake, wTake, bTake;
		int   t;
		awDone = 1'b0;
		wDone = 1'b0;
		bTake = 1'b0;
		t = 0;
		@(posedge clock);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= 32'(d);
		s_axi_bready <= 1'b1;
		while (!(awDone && wDone) && t < 200) begin
			@(negedge clock);
			awTake = s_axi_awvalid && s_axi_awready;
			wTake = s_axi_wvalid && s_axi_wready;
			@(posedge clock);
			if (awTake) begin
				s_axi_awvalid <= 1'b0;
				awDone = 1'b1;
			end
			if (wTake) begin
				s_axi_wvalid <= 1'b0;
				wDone = 1'b1;
			end
			t++;
		end
		while (!bTake && t < 200) begin
			@(negedge clock);
			bTake = s_axi_bvalid;
			lastResp = s_axi_bresp;
			@(posedge clock);
			t++;
		end
		s_axi_bready <= 1'b0;
		if (!bTake) begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value at %0t: write got no answer", $time);
		end
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a);
		logic rTake;
		int   t;
		rTake = 1'b0;
		t = 0;
		@(posedge clock);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		while (!rTake && t < 200) begin
			@(negedge clock);
			if (s_axi_arvalid && s_axi_arready) begin
				@(posedge clock);
				s_axi_arvalid <= 1'b0;
				@(negedge clock);
			end
			rTake = s_axi_rvalid;
			rdData = s_axi_rdata;
			lastResp = s_axi_rresp;
			@(posedge clock);
			t++;
		end
		s_axi_rready <= 1'b0;
		if (!rTake) begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value at %0t: read got no answer", $time);
		end
	endtask : axi_read

	task rd_check(input logic [7:0] a, input logic [7:0] exp);
		axi_read(a);
		check(rdData, 32'(exp), "register read");
		check(32'(lastResp), 32'(`NVC_RESP_OKAY), "read response");
	endtask : rd_check

	task unlock;
		axi_write(KEY, `NVC_KEY_FIRST);
		axi_write(KEY, `NVC_KEY_SECOND);
	endtask : unlock

	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		for (int i = 0; i < 6; i++) begin
			rd_check(8'(i * 4), 8'h00);
		end
		axi_read(8'h18);
		check(32'(lastResp), 32'(`NVC_RESP_SLVERR), "unmapped read");
		check(rdData, 32'h0000_0000, "unmapped data");
		axi_write(8'h40, 8'h00);
		check(32'(lastResp), 32'(`NVC_RESP_SLVERR), "unmapped write");
		$display("test reset done");
	endtask : t_reset

	task t_regs;
		axi_write(`NVC_OFF_ADDR_LOW, 8'h12);
		check(32'(lastResp), 32'(`NVC_RESP_OKAY), "write response");
		axi_write(`NVC_OFF_ADDR_HIGH, 8'hFF);
		axi_write(`NVC_OFF_DATA_LOW, 8'h34);
		axi_write(`NVC_OFF_DATA_HIGH, 8'hFF);
		axi_write(KEY, 8'h55);
		s_axi_wstrb <= 4'h0;
		axi_write(`NVC_OFF_ADDR_LOW, 8'h99);
		s_axi_wstrb <= 4'h1;
		rd_check(`NVC_OFF_ADDR_LOW, 8'h12);
		rd_check(`NVC_OFF_ADDR_HIGH, 8'h7F);
		rd_check(`NVC_OFF_DATA_HIGH, 8'h3F);
		rd_check(KEY, 8'h00);
		check(32'(memAddr), 32'h0000_7F12, "array address");
		check(32'(memWrData), 32'h0000_3F34, "array write data");
		$display("test registers done");
	endtask : t_regs

	task t_read;
		int r0;
		r0 = readCnt;
		axi_write(CTRL, 8'h01);
		repeat (3) @(posedge clock);
		check(readCnt - r0, 1, "read strobes");
		rd_check(`NVC_OFF_DATA_LOW, 8'hBC);
		rd_check(`NVC_OFF_DATA_HIGH, 8'h2A);
		rd_check(CTRL, 8'h00);
		$display("test read done");
	endtask : t_read

	task t_refuse;
		int e0, w0;
		e0 = eraseCyc;
		w0 = writeCyc;
		axi_write(CTRL, 8'h00);
		unlock();
		axi_write(CTRL, 8'h02);
		rd_check(CTRL, 8'h08);
		axi_write(CTRL, 8'h04);
		axi_write(CTRL, 8'h06);
		rd_check(CTRL, 8'h0C);
		axi_write(CTRL, 8'h04);
		axi_write(KEY, `NVC_KEY_FIRST);
		axi_write(`NVC_OFF_ADDR_LOW, 8'h00);
		axi_write(KEY, `NVC_KEY_SECOND);
		axi_write(CTRL, 8'h06);
		rd_check(CTRL, 8'h0C);
		repeat (5) @(posedge clock);
		check(eraseCyc + writeCyc - e0 - w0, 0, "refused start ran");
		$display("test refused starts done");
	endtask : t_refuse

	task automatic do_op(input logic [7:0] bits, input int ne, input int nw, input int nl);
		int e0, w0, l0, i0, t;
		e0 = eraseCyc;
		w0 = writeCyc;
		l0 = latchCnt;
		i0 = irqCnt;
		t = 0;
		axi_write(CTRL, bits);
		unlock();
		axi_write(CTRL, bits | 8'h02);
		if (ne + nw > 0) begin
			rd_check(CTRL, bits | 8'h0A);
		end
		while (irqCnt == i0 && t < 300) begin
			@(negedge clock);
			t++;
		end
		repeat (2) @(posedge clock);
		check(eraseCyc - e0, ne, "erase cycles");
		check(writeCyc - w0, nw, "write cycles");
		check(latchCnt - l0, nl, "latch loads");
		check(irqCnt - i0, 1, "completion pulses");
		rd_check(CTRL, bits & 8'hEF);
	endtask : do_op

	task t_modes;
		do_op(8'h04, `NVC_PROG_CYC, `NVC_PROG_CYC, 0);
		do_op(8'h84, 0, `NVC_PROG_CYC, 0);
		do_op(8'h94, `NVC_PROG_CYC, 0, 0);
		do_op(8'hD4, `NVC_PROG_CYC, 0, 0);
		do_op(8'hA4, 0, 0, 1);
		do_op(8'hC4, 0, `NVC_PROG_CYC, 0);
		$display("test modes done");
	endtask : t_modes

	task t_abort;
		int w0, i0, t;
		w0 = writeCyc;
		i0 = irqCnt;
		t = 0;
		axi_write(CTRL, 8'h04);
		unlock();
		axi_write(CTRL, 8'h06);
		while (memEraseActive !== 1'b1 && t < 100) begin
			@(negedge clock);
			t++;
		end
		axi_write(`NVC_OFF_ADDR_LOW, 8'h77);
		repeat (10) @(posedge clock);
		abortPin <= 1'b1;
		repeat (8) @(posedge clock);
		@(negedge clock);
		check(32'({memEraseActive, memWriteActive}), 32'h0, "phase after abort");
		@(posedge clock);
		abortPin <= 1'b0;
		repeat (60) @(posedge clock);
		check(irqCnt - i0, 0, "completion on abort");
		check(writeCyc - w0, 0, "write after abort");
		rd_check(CTRL, 8'h0C);
		rd_check(`NVC_OFF_ADDR_LOW, 8'h00);
		$display("test abort done");
	endtask : t_abort

	task final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		reset = 1'b1;
		abortPin = 1'b0;
		s_axi_awvalid = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_wvalid = 1'b0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h1;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_rready = 1'b0;
		memRdData = 14'h2ABC;
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_regs();
		t_read();
		t_refuse();
		t_modes();
		t_abort();
		final_report();
	end
endmodule : tb
`default_nettype wire
